// File: rtl/eeprom_host_pkg.sv
// Constants and types shared by the two-wire EEPROM read host
package eeprom_host_pkg;

   // ----------------------------------------------------------------
   // Device address byte
   // ----------------------------------------------------------------
   localparam logic [3:0] ARRAY_TYPE_CODE = 4'ha;
   localparam logic [3:0] ID_TYPE_CODE = 4'hb;
   localparam logic RW_WRITE = 1'h0;
   localparam logic RW_READ = 1'h1;

   // ----------------------------------------------------------------
   // Word address layout
   // ----------------------------------------------------------------
   localparam int WORD_ADDR_W = 12;
   localparam int ID_OFFSET_W = 5;
   localparam logic [5:0] ID_PAGE_BYTES = 6'h20;
   // Upper address byte of a freeze command: only the lock-select bit is set
   localparam logic [7:0] ID_LOCK_ADDR_HI = 8'h04;
   localparam logic [7:0] ID_LOCK_ADDR_LO = 8'h00;
   // Freeze data byte: bit one set, the rest are don't care
   localparam logic [7:0] ID_LOCK_DATA = 8'h02;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int SCL_PERIOD_NS = 10000;
   localparam int QUARTER_CYCLES = (SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
   localparam int PROGRAM_INTERVAL_US = 10000;
   localparam int PROGRAM_INTERVAL_CYCLES = (PROGRAM_INTERVAL_US * 1000 + CLK_PERIOD_NS - 1)
                                            / CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // Commands and byte kinds
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      OP_CURRENT_READ = 2'h0,
      OP_RANDOM_READ = 2'h1,
      OP_ID_READ = 2'h2,
      OP_ID_FREEZE = 2'h3
   } op_t;

   typedef enum logic [2:0] {
      KIND_DEV_WRITE = 3'h0,
      KIND_ADDR_HI = 3'h1,
      KIND_ADDR_LO = 3'h2,
      KIND_DEV_READ = 3'h3,
      KIND_DATA = 3'h4
   } kind_t;

endpackage : eeprom_host_pkg

// File: rtl/eeprom_read_host.sv
// Two-wire host that reads a serial EEPROM, reads and freezes its ID page
`timescale 1ns/100ps

// ------------------------------------------------------------------
// Read data buffer
// ------------------------------------------------------------------
module read_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic do_wr;
   logic do_rd;
   logic [AW-1:0] next_rd_ptr;
   logic [AW:0] next_count;

   assign in_ready = count != (AW+1)'(DEPTH);
   assign do_wr = in_valid && in_ready;
   assign do_rd = out_valid && out_ready;
   assign next_rd_ptr = !do_rd ? rd_ptr : (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
   assign next_count = count + (AW+1)'(do_wr) - (AW+1)'(do_rd);

   always_ff @(posedge clk) begin
      if (do_wr) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
         out_valid <= 1'b0;
         out_data <= '0;
      end else begin
         if (do_wr) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         end
         rd_ptr <= next_rd_ptr;
         count <= next_count;
         // Head word is registered so the stream leaves from flops;
         // a word written into an empty buffer bypasses the array
         out_valid <= next_count != '0;
         out_data <= (do_wr && wr_ptr == next_rd_ptr) ? in_data : mem[next_rd_ptr];
      end
   end
endmodule : read_fifo

// ------------------------------------------------------------------
// Host controller
// ------------------------------------------------------------------
module eeprom_read_host
   import eeprom_host_pkg::*;
#(
   parameter int LEN_W = 13,
   parameter int FIFO_DEPTH = 32,
   parameter int QUARTER = QUARTER_CYCLES,
   parameter int PROGRAM_WAIT = PROGRAM_INTERVAL_CYCLES
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Command port
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire eeprom_host_pkg::op_t cmd_op,
   input wire logic [2:0] cmd_chip_select,
   input wire logic [eeprom_host_pkg::WORD_ADDR_W-1:0] cmd_addr,
   input wire logic [LEN_W-1:0] cmd_len,
   // Status
   output logic busy,
   output logic done,
   output logic nack_error,
   // Read data stream
   output logic rd_valid,
   input wire logic rd_ready,
   output logic [7:0] rd_data,
   // Two-wire bus, open drain
   input wire logic scl_in,
   output logic scl_out,
   output logic scl_oe,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe
);
   import eeprom_host_pkg::*;

   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_START = 6'h02,
      ST_SEND = 6'h04,
      ST_RECV = 6'h08,
      ST_STOP = 6'h10,
      ST_WAIT = 6'h20
   } state_t;

   state_t st;
   op_t op;
   kind_t kind;
   logic [2:0] chip_sel;
   logic [WORD_ADDR_W-1:0] addr;
   logic [LEN_W-1:0] remaining;
   logic addr_done;
   logic [1:0] q;
   logic [$clog2(QUARTER+1)-1:0] qcnt;
   logic [3:0] bit_idx;
   logic [7:0] shreg;
   logic ack_seen_high;
   logic [31:0] wait_cnt;
   logic sda_meta;
   logic sda_sync;
   logic tick;
   logic stall;
   logic step;
   logic push;
   logic [7:0] push_data;
   logic fifo_in_ready;
   logic next_scl_low;
   logic next_sda_low;
   logic [LEN_W-1:0] id_room;

   // ----------------------------------------------------------------
   // Byte to send for each kind
   // ----------------------------------------------------------------
   function automatic logic [7:0] tx_byte(kind_t k, op_t o, logic [2:0] cs,
                                          logic [WORD_ADDR_W-1:0] a);
      logic [3:0] type_code;
      logic [7:0] b;
      type_code = (o == OP_ID_READ || o == OP_ID_FREEZE) ? ID_TYPE_CODE : ARRAY_TYPE_CODE;
      b = 8'h00;
      case (k)
         KIND_DEV_WRITE: b = {type_code, cs, RW_WRITE};
         KIND_DEV_READ: b = {type_code, cs, RW_READ};
         KIND_ADDR_HI: begin
            if (o == OP_ID_FREEZE) b = ID_LOCK_ADDR_HI;
            else if (o == OP_ID_READ) b = 8'h00;
            else b = 8'(a[WORD_ADDR_W-1:8]);
         end
         KIND_ADDR_LO: begin
            if (o == OP_ID_FREEZE) b = ID_LOCK_ADDR_LO;
            else if (o == OP_ID_READ) b = 8'(a[ID_OFFSET_W-1:0]);
            else b = a[7:0];
         end
         KIND_DATA: b = ID_LOCK_DATA;
         default: b = 8'h00;
      endcase
      return b;
   endfunction : tx_byte

   // ----------------------------------------------------------------
   // Input synchroniser and quarter-bit timing
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      sda_meta <= sda_in;
      sda_sync <= sda_meta;
   end

   assign tick = qcnt == ($bits(qcnt))'(QUARTER - 1);
   // Bus clock is held low before a data byte while the buffer is full
   assign stall = (st == ST_RECV) && (bit_idx == 4'h0) && (q == 2'h0) && !fifo_in_ready;
   assign step = tick && !stall;
   assign id_room = LEN_W'(ID_PAGE_BYTES) - LEN_W'(cmd_addr[ID_OFFSET_W-1:0]);

   always_ff @(posedge clk) begin
      if (reset || st == ST_IDLE || st == ST_WAIT || tick) begin
         qcnt <= '0;
      end else begin
         qcnt <= qcnt + 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Line levels per quarter
   // ----------------------------------------------------------------
   always_comb begin
      next_scl_low = 1'b0;
      next_sda_low = 1'b0;
      case (st)
         ST_START: begin
            next_scl_low = (q == 2'h0) || (q == 2'h3);
            next_sda_low = q[1];
         end
         ST_SEND: begin
            next_scl_low = (q == 2'h0) || (q == 2'h3);
            next_sda_low = (bit_idx < 4'h8) && !shreg[7];
         end
         ST_RECV: begin
            next_scl_low = (q == 2'h0) || (q == 2'h3);
            next_sda_low = (bit_idx == 4'h8) && (remaining != LEN_W'(1));
         end
         ST_STOP: begin
            next_scl_low = q == 2'h0;
            next_sda_low = !q[1];
         end
         default: begin
            next_scl_low = 1'b0;
            next_sda_low = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         scl_oe <= 1'b0;
         sda_oe <= 1'b0;
         scl_out <= 1'b0;
         sda_out <= 1'b0;
      end else begin
         scl_oe <= next_scl_low;
         sda_oe <= next_sda_low;
         scl_out <= 1'b0;
         sda_out <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Transfer sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         st <= ST_IDLE;
         op <= OP_CURRENT_READ;
         kind <= KIND_DEV_WRITE;
         chip_sel <= 3'h0;
         addr <= '0;
         remaining <= '0;
         addr_done <= 1'b0;
         q <= 2'h0;
         bit_idx <= 4'h0;
         shreg <= 8'h00;
         ack_seen_high <= 1'b0;
         wait_cnt <= 32'h0;
         cmd_ready <= 1'b0;
         busy <= 1'b0;
         done <= 1'b0;
         nack_error <= 1'b0;
         push <= 1'b0;
         push_data <= 8'h00;
      end else begin
         done <= 1'b0;
         push <= 1'b0;
         case (st)
            ST_IDLE: begin
               cmd_ready <= 1'b1;
               if (cmd_valid && cmd_ready) begin
                  cmd_ready <= 1'b0;
                  busy <= 1'b1;
                  nack_error <= 1'b0;
                  op <= cmd_op;
                  chip_sel <= cmd_chip_select;
                  addr <= cmd_addr;
                  addr_done <= cmd_op == OP_CURRENT_READ;
                  q <= 2'h0;
                  remaining <= (cmd_len == '0) ? LEN_W'(1) : cmd_len;
                  if (cmd_op == OP_ID_READ && cmd_len > id_room) begin
                     remaining <= id_room;
                  end
                  st <= ST_START;
               end
            end
            ST_START: begin
               if (step) begin
                  q <= q + 1'b1;
                  if (q == 2'h3) begin
                     kind <= addr_done ? KIND_DEV_READ : KIND_DEV_WRITE;
                     shreg <= tx_byte(addr_done ? KIND_DEV_READ : KIND_DEV_WRITE, op,
                                      chip_sel, addr);
                     bit_idx <= 4'h0;
                     st <= ST_SEND;
                  end
               end
            end
            ST_SEND: begin
               if (step) begin
                  q <= q + 1'b1;
                  if (q == 2'h1 && bit_idx == 4'h8) begin
                     ack_seen_high <= sda_sync;
                  end
                  if (q == 2'h3) begin
                     bit_idx <= bit_idx + 1'b1;
                     shreg <= {shreg[6:0], 1'b0};
                     if (bit_idx == 4'h8) begin
                        bit_idx <= 4'h0;
                        if (ack_seen_high) begin
                           nack_error <= 1'b1;
                           st <= ST_STOP;
                        end else begin
                           case (kind)
                              KIND_DEV_WRITE: begin
                                 kind <= KIND_ADDR_HI;
                                 shreg <= tx_byte(KIND_ADDR_HI, op, chip_sel, addr);
                              end
                              KIND_ADDR_HI: begin
                                 kind <= KIND_ADDR_LO;
                                 shreg <= tx_byte(KIND_ADDR_LO, op, chip_sel, addr);
                              end
                              KIND_ADDR_LO: begin
                                 if (op == OP_ID_FREEZE) begin
                                    kind <= KIND_DATA;
                                    shreg <= tx_byte(KIND_DATA, op, chip_sel, addr);
                                 end else begin
                                    addr_done <= 1'b1;
                                    st <= ST_START;
                                 end
                              end
                              KIND_DEV_READ: st <= ST_RECV;
                              default: st <= ST_STOP;
                           endcase
                        end
                     end
                  end
               end
            end
            ST_RECV: begin
               if (step) begin
                  q <= q + 1'b1;
                  if (q == 2'h1 && bit_idx < 4'h8) begin
                     shreg <= {shreg[6:0], sda_sync};
                  end
                  if (q == 2'h3) begin
                     bit_idx <= bit_idx + 1'b1;
                     if (bit_idx == 4'h7) begin
                        push <= 1'b1;
                        push_data <= shreg;
                     end
                     if (bit_idx == 4'h8) begin
                        bit_idx <= 4'h0;
                        remaining <= remaining - 1'b1;
                        if (remaining == LEN_W'(1)) begin
                           st <= ST_STOP;
                        end
                     end
                  end
               end
            end
            ST_STOP: begin
               if (step) begin
                  q <= q + 1'b1;
                  if (q == 2'h3) begin
                     if (op == OP_ID_FREEZE && !nack_error) begin
                        wait_cnt <= 32'(PROGRAM_WAIT - 1);
                        st <= ST_WAIT;
                     end else begin
                        busy <= 1'b0;
                        done <= 1'b1;
                        st <= ST_IDLE;
                     end
                  end
               end
            end
            ST_WAIT: begin
               // Device ignores the bus while it programs the freeze
               wait_cnt <= wait_cnt - 1'b1;
               if (wait_cnt == 32'h0) begin
                  busy <= 1'b0;
                  done <= 1'b1;
                  st <= ST_IDLE;
               end
            end
            default: st <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Received bytes go out through the buffer
   // ----------------------------------------------------------------
   read_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH)
   ) u_read_fifo (
      .clk(clk),
      .reset(reset),
      .in_valid(push),
      .in_ready(fifo_in_ready),
      .in_data(push_data),
      .out_valid(rd_valid),
      .out_ready(rd_ready),
      .out_data(rd_data)
   );

endmodule : eeprom_read_host

// File: verif/eeprom_read_host_properties.sv
// Port checker for the two-wire EEPROM read host
`timescale 1ns/100ps
module eeprom_read_host_properties
   import eeprom_host_pkg::*;
#(
   parameter int QUARTER = 3,
   parameter int PROGRAM_WAIT = 20
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Command and status
   input wire logic cmd_valid,
   input wire logic cmd_ready,
   input wire eeprom_host_pkg::op_t cmd_op,
   input wire logic busy,
   input wire logic done,
   input wire logic nack_error,
   // Stream and bus
   input wire logic rd_valid,
   input wire logic rd_ready,
   input wire logic [7:0] rd_data,
   input wire logic scl_out,
   input wire logic scl_oe,
   input wire logic sda_out,
   input wire logic sda_oe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   logic [7:0] lo_cnt;
   logic [7:0] hi_cnt;
   logic [31:0] idle_cnt;
   logic freeze_op;
   // ---------------------------------------------------------------
   // Helper counters; the clock low and high counters saturate so long idles cannot wrap
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset || !scl_oe) lo_cnt <= 8'h00;
      else if (lo_cnt != 8'hff) lo_cnt <= lo_cnt + 8'h01;
   end
   // Line has been free since reset, so the first start sees a long high phase
   always_ff @(posedge clk) begin
      if (reset) hi_cnt <= 8'hff;
      else if (scl_oe) hi_cnt <= 8'h00;
      else if (hi_cnt != 8'hff) hi_cnt <= hi_cnt + 8'h01;
   end
   // Busy with the bus already released: the program wait
   always_ff @(posedge clk) begin
      if (reset || !busy || scl_oe || sda_oe) idle_cnt <= 32'h0;
      else idle_cnt <= idle_cnt + 32'h1;
   end
   always_ff @(posedge clk) begin
      if (reset) freeze_op <= 1'b0;
      else if (cmd_valid && cmd_ready) freeze_op <= (cmd_op == OP_ID_FREEZE);
   end
   AST_NO_HIGH_DRIVE: assert property (scl_out == 1'b0 && sda_out == 1'b0)
      else $error("bus driven high");
   AST_IDLE_BUS_FREE: assert property (!busy |-> !scl_oe && !sda_oe)
      else $error("bus held while idle");
   AST_SCL_LOW_MIN: assert property ($fell(scl_oe) |-> lo_cnt >= QUARTER)
      else $error("clock low phase too short");
   AST_SCL_HIGH_MIN: assert property ($rose(scl_oe) |-> hi_cnt >= 2 * QUARTER)
      else $error("clock high phase too short");
   AST_DONE_PULSE: assert property (done |=> !done)
      else $error("done longer than one cycle");
   AST_READY_AFTER_DONE: assert property (done |-> ##[1:2] cmd_ready)
      else $error("not ready after done");
   AST_TAKE_BUSY: assert property (cmd_valid && cmd_ready |=> busy && !cmd_ready && !nack_error)
      else $error("take did not start command");
   AST_PROGRAM_WAIT: assert property (done |->
      (freeze_op ? idle_cnt >= PROGRAM_WAIT : idle_cnt < PROGRAM_WAIT))
      else $error("program wait wrong");
   AST_STREAM_HOLD: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
      else $error("stream word dropped");
   AST_NACK_STAYS: assert property (nack_error && !(cmd_valid && cmd_ready) |=> nack_error)
      else $error("nack flag lost");
   COV_FREEZE: cover property (done && freeze_op);
   COV_NACK: cover property (done && nack_error);
   COV_STALL: cover property (rd_valid && !rd_ready && busy);
endmodule : eeprom_read_host_properties

bind eeprom_read_host eeprom_read_host_properties #(.QUARTER(QUARTER),
   .PROGRAM_WAIT(PROGRAM_WAIT)) u_props (.clk(clk), .reset(reset), .cmd_valid(cmd_valid),
   .cmd_ready(cmd_ready), .cmd_op(cmd_op), .busy(busy), .done(done),
   .nack_error(nack_error), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
   .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out), .sda_oe(sda_oe));

// File: verif/eeprom_model.sv
// Behavioural two-wire EEPROM that answers the host
`timescale 1ns/100ps
module eeprom_model
   import eeprom_host_pkg::*;
#(
   parameter logic [2:0] STRAP = 3'h5
) (
   // Sampling clock
   input wire logic clk,
   // Bus levels and data pull-down
   input wire logic scl,
   input wire logic sda,
   output logic dev_oe
);
   typedef enum logic [2:0] {M_IDLE, M_DEV, M_HI, M_LO, M_WR, M_TX} mode_t;
   logic [7:0] mem [4096];
   logic [7:0] idp [32];
   logic [11:0] ctr;
   logic [7:0] sh, hi, tx;
   logic [3:0] cnt;
   mode_t mode;
   logic id_sel, locked, pscl, psda;
   // Counter and lock live only in this initial block: power stays on
   initial begin
      for (int i = 0; i < 4096; i++) mem[i] = i[7:0] ^ {i[11:8], i[11:8]};
      for (int i = 0; i < 32; i++) idp[i] = {3'b110, i[4:0]};
      ctr = 12'h000;
      mode = M_IDLE;
      cnt = 4'h0;
      locked = 1'b0;
      id_sel = 1'b0;
      dev_oe = 1'b0;
      pscl = 1'b1;
      psda = 1'b1;
   end
   // ---------------------------------------------------------------
   // Bus engine, edges found by sampling
   // ---------------------------------------------------------------
   always @(posedge clk) begin
      pscl <= scl;
      psda <= sda;
      if (scl && pscl && psda && !sda) begin
         mode <= M_DEV;
         cnt <= 4'h0;
         dev_oe <= 1'b0;
      end else if (scl && pscl && !psda && sda) begin
         mode <= M_IDLE;
         dev_oe <= 1'b0;
      end else if (scl && !pscl && mode != M_IDLE) begin
         cnt <= cnt + 4'h1;
         if (cnt < 4'h8) sh <= {sh[6:0], sda};
         else if (mode == M_TX && sda) mode <= M_IDLE;
      end else if (!scl && pscl && mode != M_IDLE) begin
         if (cnt == 4'h8) begin
            dev_oe <= 1'b0;
            case (mode)
               M_DEV: begin
                  if ((sh[7:4] == ARRAY_TYPE_CODE || sh[7:4] == ID_TYPE_CODE)
                      && sh[3:1] == STRAP) begin
                     dev_oe <= 1'b1;
                     id_sel <= (sh[7:4] == ID_TYPE_CODE);
                     mode <= sh[0] ? M_TX : M_HI;
                  end else mode <= M_IDLE;
               end
               M_HI: begin
                  hi <= sh;
                  dev_oe <= 1'b1;
                  mode <= M_LO;
               end
               M_LO: begin
                  ctr <= {hi[3:0], sh};
                  dev_oe <= 1'b1;
                  mode <= M_WR;
               end
               M_WR: begin
                  if (id_sel && hi[2] && sh[1]) locked <= 1'b1;
                  dev_oe <= !(id_sel && locked && !hi[2]);
                  // Write counter rolls over inside its own page
                  ctr <= {ctr[11:5], ctr[4:0] + 5'h01};
               end
               default: ;
            endcase
         end else if (cnt == 4'h9) begin
            cnt <= 4'h0;
            dev_oe <= 1'b0;
            if (mode == M_TX) begin
               tx <= id_sel ? idp[ctr[4:0]] : mem[ctr];
               dev_oe <= !(id_sel ? idp[ctr[4:0]][7] : mem[ctr][7]);
               // Array wraps at the top, the ID page within itself
               ctr <= id_sel ? {ctr[11:5], ctr[4:0] + 5'h01} : ctr + 12'h001;
            end
         end else if (mode == M_TX) dev_oe <= !tx[3'(7 - cnt)];
      end
   end
endmodule : eeprom_model

// File: verif/testbench.sv
// Self-checking bench for the two-wire EEPROM read host
`timescale 1ns/100ps
module testbench;
   import eeprom_host_pkg::*;
   localparam logic [2:0] CS = 3'h5;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic cmd_valid = 1'b0;
   op_t cmd_op = OP_CURRENT_READ;
   logic [2:0] cmd_chip_select = CS;
   logic [11:0] cmd_addr = 12'h000;
   logic [12:0] cmd_len = 13'h0000;
   logic rd_ready = 1'b0;
   logic cmd_ready, busy, done, nack_error, rd_valid, scl_out, scl_oe, sda_out, sda_oe, dev_oe;
   logic [7:0] rd_data;
   logic [15:0] lfsr = 16'h001d;
   logic stall = 1'b0;
   logic [11:0] nxt;
   logic [7:0] exp_q[$];
   int err_count = 0;
   int total_checks = 0;
   int k;
   wire scl = scl_oe ? scl_out : 1'b1;
   wire sda = (sda_oe ? sda_out : 1'b1) & ~dev_oe;

   eeprom_read_host #(.QUARTER(3), .PROGRAM_WAIT(20)) u_eeprom_read_host (.clk(clk),
      .reset(reset), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
      .cmd_chip_select(cmd_chip_select), .cmd_addr(cmd_addr), .cmd_len(cmd_len), .busy(busy),
      .done(done), .nack_error(nack_error), .rd_valid(rd_valid), .rd_ready(rd_ready),
      .rd_data(rd_data), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda),
      .sda_out(sda_out), .sda_oe(sda_oe));
   eeprom_model #(.STRAP(CS)) u_eeprom_model (.clk(clk), .scl(scl), .sda(sda), .dev_oe(dev_oe));

   always #5 clk = ~clk;

   function automatic logic [15:0] step(logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : step

   task automatic chk8(string n, logic [7:0] e, logic [7:0] g);
      total_checks++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk8

   task automatic chk1(string n, logic e, logic g);
      total_checks++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %s expected %b seen %b", n, e, g);
      end
   endtask : chk1

   task automatic give_verdict();
      if (err_count == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : give_verdict

   // Expected bytes: array pattern or ID page pattern, in bus order
   task automatic expect_bytes(logic [11:0] a, int n, logic id);
      for (int i = 0; i < n; i++) begin
         if (id) exp_q.push_back({3'b110, 5'(a[4:0] + 5'(i))});
         else exp_q.push_back(8'(a + 12'(i)) ^ {4'(12'(a + 12'(i)) >> 8), 4'(12'(a + 12'(i)) >> 8)});
      end
   endtask : expect_bytes

   task automatic send(op_t op, logic [2:0] cs, logic [11:0] a, logic [12:0] n);
      for (int i = 0; i < 50 && cmd_ready !== 1'b1; i++) @(negedge clk);
      cmd_op = op;
      cmd_chip_select = cs;
      cmd_addr = a;
      cmd_len = n;
      cmd_valid = 1'b1;
      @(negedge clk);
      cmd_valid = 1'b0;
   endtask : send

   task automatic finish_cmd(logic nack);
      for (int i = 0; i < 40000 && done !== 1'b1; i++) @(negedge clk);
      chk1("done", 1'b1, done);
      chk1("nack_error", nack, nack_error);
      for (int i = 0; i < 300 && exp_q.size() != 0; i++) @(negedge clk);
      chk1("all data seen", 1'b1, exp_q.size() == 0);
   endtask : finish_cmd

   // ---------------------------------------------------------------
   // Stimulus at the falling edge, scoreboard at the rising edge
   // ---------------------------------------------------------------
   always @(negedge clk) begin
      lfsr <= step(lfsr);
      rd_ready <= !stall && (lfsr[0] || lfsr[1]);
   end

   always @(posedge clk) begin
      if (!reset && rd_valid && rd_ready) begin
         if (exp_q.size() == 0) chk1("unexpected data", 1'b0, 1'b1);
         else chk8("rd_data", exp_q.pop_front(), rd_data);
      end
   end

   initial begin
      repeat (80000) @(posedge clk);
      err_count++;
      give_verdict();
   end

   initial begin
      repeat (12) @(negedge clk);
      reset = 1'b0;
      repeat (3) @(negedge clk);
      nxt = lfsr[11:0];
      k = 2 + int'(lfsr[13:12]);
      expect_bytes(nxt, k, 1'b0);
      send(OP_RANDOM_READ, CS, nxt, 13'(k));
      finish_cmd(1'b0);
      // Counter carries over to a current read
      expect_bytes(nxt + 12'(k), 2, 1'b0);
      send(OP_CURRENT_READ, CS, 12'h000, 13'h0002);
      finish_cmd(1'b0);
      // Wrap at the top while the buffer fills and the bus must stall
      stall = 1'b1;
      expect_bytes(12'hffe, 40, 1'b0);
      send(OP_RANDOM_READ, CS, 12'hffe, 13'h0028);
      k = 0;
      for (int i = 0; i < 20000 && k < 60; i++) begin
         @(negedge clk);
         k = scl_oe ? k + 1 : 0;
      end
      chk1("held while full", 1'b1, busy);
      stall = 1'b0;
      finish_cmd(1'b0);
      expect_bytes(12'h026, 1, 1'b0);
      send(OP_CURRENT_READ, CS, 12'h000, 13'h0000);
      finish_cmd(1'b0);
      send(OP_RANDOM_READ, CS ^ 3'h2, lfsr[11:0], 13'h0001);
      finish_cmd(1'b1);
      // Offset 10: the page end leaves 22 bytes when more are asked
      expect_bytes(12'h00a, 22, 1'b1);
      send(OP_ID_READ, CS, {lfsr[6:0], 5'h0a}, 13'h0028);
      finish_cmd(1'b0);
      chk1("id page open", 1'b0, u_eeprom_model.locked);
      send(OP_ID_FREEZE, CS, 12'h000, 13'h0000);
      finish_cmd(1'b0);
      chk1("id page frozen", 1'b1, u_eeprom_model.locked);
      give_verdict();
   end
endmodule : testbench
